//--- hdl/abct_pkg.sv
// Purpose: Shared constants for the bundle configuration table.
// Assumes: APB with 32-bit data, byte addresses.
// Notes: Offsets are byte addresses inside the engine register space.
`default_nettype none
package abct_pkg;
    localparam logic [15:0] ABCT_BASE = 16'h8000;
    localparam logic [15:0] ABCT_PLANE_SPAN = 16'h0100;
    localparam int ABCT_NUM_PLANES = 5;
    localparam int ABCT_NUM_BUNDLES = 64;
    localparam logic [11:0] ABCT_OFF_RX_ID = 12'h000;
    localparam logic [11:0] ABCT_OFF_GENERAL = 12'h100;
    localparam logic [11:0] ABCT_OFF_TOP = 12'h400;
    localparam logic [31:0] ABCT_WORD_RESET = 32'h00000000;
    // Field positions of the general setup word.
    localparam int ABCT_DEPTH_LSB = 22;
    localparam int ABCT_PAYLOAD_LSB = 20;
    localparam int ABCT_TS_HDR_BIT = 19;
    localparam int ABCT_CTRL_WORD_BIT = 18;
    localparam int ABCT_DEST_LSB = 16;
    localparam int ABCT_LOST_LSB = 9;
    localparam int ABCT_SLOTS_LSB = 4;
    localparam int ABCT_KEEP_BAD_BIT = 3;
    localparam int ABCT_ENCAP_LSB = 1;
    localparam int ABCT_RBIT_BIT = 0;
    typedef enum logic [1:0] {
        ABCT_PAY_HDLC = 2'b00,
        ABCT_PAY_AAL1 = 2'b01,
        ABCT_PAY_RSVD = 2'b10,
        ABCT_PAY_SATOP = 2'b11
    } abct_payload_t;
    typedef enum logic [1:0] {
        ABCT_DST_RSVD = 2'b00,
        ABCT_DST_ETH = 2'b01,
        ABCT_DST_CPU = 2'b10,
        ABCT_DST_TDM = 2'b11
    } abct_dest_t;
    typedef enum logic [1:0] {
        ABCT_ENC_MPLS = 2'b00,
        ABCT_ENC_UDP = 2'b01,
        ABCT_ENC_L2TP = 2'b10,
        ABCT_ENC_MEF = 2'b11
    } abct_encap_t;
endpackage
`default_nettype wire

//--- hdl/abct_field_decode.sv
// Purpose: Splits a general setup word of any bundle into fields, whatever its payload kind.
// Assumes: Word supplied from a flip-flop of the table.
// Notes: Purely combinational.
`default_nettype none
module abct_field_decode
    import abct_pkg::*;
(
    input wire logic [31:0] word,
    output logic [9:0] jitter_depth,
    output abct_payload_t payload_kind,
    output logic send_timestamp_hdr_on,
    output logic ctrl_word_on,
    output abct_dest_t dest,
    output logic [6:0] lost_fill_limit,
    output logic [4:0] slot_count_minus_one,
    output logic keep_bad_packets,
    output abct_encap_t encap,
    output logic set_r_bit
);
    assign jitter_depth = word[ABCT_DEPTH_LSB +: 10];
    assign payload_kind = abct_payload_t'(word[ABCT_PAYLOAD_LSB +: 2]);
    assign send_timestamp_hdr_on = word[ABCT_TS_HDR_BIT];
    assign ctrl_word_on = word[ABCT_CTRL_WORD_BIT];
    assign dest = abct_dest_t'(word[ABCT_DEST_LSB +: 2]);
    assign lost_fill_limit = word[ABCT_LOST_LSB +: 7];
    assign slot_count_minus_one = word[ABCT_SLOTS_LSB +: 5];
    assign keep_bad_packets = word[ABCT_KEEP_BAD_BIT];
    assign encap = abct_encap_t'(word[ABCT_ENCAP_LSB +: 2]);
    assign set_r_bit = word[ABCT_RBIT_BIT];
endmodule
`default_nettype wire

//--- hdl/abct_table.sv
// Purpose: Bundle configuration table with APB access and field lookup.
// Assumes: Single clock mclk, synchronous active-high reset rst.
// Notes: Datapath looks up one bundle by index and gets its fields.
`default_nettype none
module abct_table
    import abct_pkg::*;
#(
    parameter int NUM_BUNDLES = ABCT_NUM_BUNDLES
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] lookup_bundle,
    output logic [31:0] rx_bundle_id,
    output logic [9:0] jitter_depth,
    output logic aal1_selected,
    output abct_payload_t payload_kind,
    output logic send_timestamp_hdr_on,
    output logic ctrl_word_on,
    output abct_dest_t dest,
    output logic [6:0] lost_fill_limit,
    output logic [4:0] slot_count_minus_one,
    output logic keep_bad_packets,
    output abct_encap_t encap,
    output logic set_r_bit
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Words have no defined reset value, but they are cleared anyway so
    // simulation never shows unknowns on the lookup outputs.
    logic [31:0] table_mem [ABCT_NUM_PLANES][NUM_BUNDLES];
    logic [31:0] lookup_w0;
    logic [31:0] lookup_w1;
    logic [31:0] next_prdata;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic in_table(input logic [15:0] a);
        in_table = (a[15:11] == ABCT_BASE[15:11]) &&
                   (a[10:8] < 3'(ABCT_NUM_PLANES)) &&
                   (a[7:2] < 6'(NUM_BUNDLES - 1) + 6'h01 ||
                    NUM_BUNDLES == 64) &&
                   (a[1:0] == 2'b00);
    endfunction

    // Plane p sits at p times 0x100; bundle index is the word number.
    wire logic [2:0] acc_plane = paddr[10:8];
    wire logic [5:0] acc_bundle = paddr[7:2];
    wire logic acc_hit = in_table(paddr);
    wire logic access = psel && penable;

    // Zero wait states: the access phase completes in one cycle.
    assign pready = 1'b1;
    assign pslverr = access && !acc_hit;

    // ----------------------------------------------------------------
    // Writes with byte strobes
    // ----------------------------------------------------------------
    genvar gp;
    genvar gb;
    generate
        for (gp = 0; gp < ABCT_NUM_PLANES; gp++) begin : g_plane
            for (gb = 0; gb < NUM_BUNDLES; gb++) begin : g_bundle
                always_ff @(posedge mclk) begin
                    if (rst) begin
                        table_mem[gp][gb] <= ABCT_WORD_RESET;
                    end else if (access && pwrite && acc_hit &&
                                 acc_plane == 3'(gp) &&
                                 acc_bundle == 6'(gb)) begin
                        for (int k = 0; k < 4; k++) begin
                            if (pstrb[k]) begin
                                table_mem[gp][gb][8*k +: 8] <=
                                    pwdata[8*k +: 8];
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Read data is computed in the setup cycle and registered, so it
    // is stable during the access phase.
    always_comb begin
        next_prdata = 32'h00000000;
        if (psel && !penable && !pwrite && in_table(paddr)) begin
            next_prdata = table_mem[paddr[10:8]][paddr[7:2]];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------------------------------
    // Datapath lookup
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            lookup_w0 <= ABCT_WORD_RESET;
            lookup_w1 <= ABCT_WORD_RESET;
        end else begin
            lookup_w0 <= table_mem[0][lookup_bundle];
            lookup_w1 <= table_mem[1][lookup_bundle];
        end
    end

    assign rx_bundle_id = lookup_w0;
    // Fields of word 1 only mean AAL1 settings when the selector says so.
    assign aal1_selected = (payload_kind == ABCT_PAY_AAL1);

    abct_field_decode u_decode (
        .word(lookup_w1),
        .jitter_depth(jitter_depth),
        .payload_kind(payload_kind),
        .send_timestamp_hdr_on(send_timestamp_hdr_on),
        .ctrl_word_on(ctrl_word_on),
        .dest(dest),
        .lost_fill_limit(lost_fill_limit),
        .slot_count_minus_one(slot_count_minus_one),
        .keep_bad_packets(keep_bad_packets),
        .encap(encap),
        .set_r_bit(set_r_bit)
    );
endmodule
`default_nettype wire

//--- test/abct_table_asserts.sv
// Purpose: Port assertions for the bundle configuration table.
// Assumes: One clock, synchronous active-high reset, full-word writes.
// Notes: Bound to every table instance.
`default_nettype none
module abct_table_asserts
    import abct_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] lookup_bundle,
    input wire logic [31:0] rx_bundle_id,
    input wire logic [9:0] jitter_depth,
    input wire logic aal1_selected,
    input wire abct_payload_t payload_kind,
    input wire logic [4:0] slot_count_minus_one
);
// ----
// Checks
// ----
default clocking @(posedge mclk); endclocking
default disable iff (rst);
logic acc;
logic ok;
assign acc = psel && penable;
assign ok = paddr >= 16'h8000 && paddr < 16'h8500 && paddr[1:0] == 2'h0;
// The index must hold one more edge, as the lookup is registered.
sequence wr_plane(logic [15:0] base);
    acc && pwrite && pstrb == 4'hF && paddr == base + {lookup_bundle, 2'h0}
    ##1 $stable(lookup_bundle);
endsequence
AST_READY: assert property (acc |-> pready)
    else $error("access phase without ready");
AST_UNMAPPED: assert property (acc && !ok |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
AST_MAPPED: assert property (acc && ok |-> !pslverr)
    else $error("mapped access refused");
AST_AAL1: assert property (aal1_selected == (payload_kind == ABCT_PAY_AAL1))
    else $error("aal1 flag disagrees with payload kind");
AST_RX_ID: assert property (wr_plane(16'h8000) |=>
    rx_bundle_id == $past(pwdata, 2)) else $error("bundle id not updated");
AST_DEPTH: assert property (wr_plane(16'h8100) |=>
    jitter_depth == 10'($past(pwdata, 2) >> 22)) else $error("depth wrong");
AST_SLOTS: assert property (wr_plane(16'h8100) |=>
    slot_count_minus_one == 5'($past(pwdata, 2) >> 4))
    else $error("slot count wrong");
AST_HOLD: assert property ((!psel && $stable(lookup_bundle)) [*2] |=>
    $stable(rx_bundle_id)) else $error("bundle id moved without write");
endmodule
bind abct_table abct_table_asserts u_chk (.mclk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .lookup_bundle, .rx_bundle_id, .jitter_depth, .aal1_selected,
    .payload_kind, .slot_count_minus_one);
`default_nettype wire

//--- test/tb_top.sv
// Purpose: Self-checking bench for the bundle configuration table.
// Assumes: APB master, one transfer at a time, full-word strobes.
// Notes: Expectations come from the field layout, never the design.
`default_nettype none
module tb_top
    import abct_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;
logic mclk, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
logic pready, pslverr, aal1_selected, e, send_timestamp_hdr_on;
logic ctrl_word_on, keep_bad_packets, set_r_bit;
logic [15:0] paddr = 16'h0;
logic [31:0] pwdata = 32'h0, prdata, rx_bundle_id, q, fields;
logic [3:0] pstrb = 4'hF;
logic [5:0] lookup_bundle = 6'h0;
logic [9:0] jitter_depth;
logic [6:0] lost_fill_limit;
logic [4:0] slot_count_minus_one;
logic [15:0] bad [3] = '{16'h7FFC, 16'h8500, 16'h8002};
abct_payload_t payload_kind;
abct_dest_t dest;
abct_encap_t encap;
int fail_count = 0, samples_checked = 0, cycles = 0;
abct_table uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .lookup_bundle, .rx_bundle_id,
    .jitter_depth, .aal1_selected, .payload_kind, .send_timestamp_hdr_on,
    .ctrl_word_on, .dest, .lost_fill_limit, .slot_count_minus_one,
    .keep_bad_packets, .encap, .set_r_bit);
assign fields = {jitter_depth, payload_kind, send_timestamp_hdr_on,
    ctrl_word_on, dest, lost_fill_limit, slot_count_minus_one,
    keep_bad_packets, encap, set_r_bit};
initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
end
task automatic give_verdict();
    $display("compared %0d, wrong %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
        fail_count++;
        give_verdict();
    end
end
task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
        fail_count++;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
endtask
// Waits for ready without assuming a count; the cap only stops a hang.
task automatic apb(input logic wr, input logic [15:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
        @(posedge mclk);
        n++;
    end while (pready !== 1'h1 && n < 100);
    if (n == 100) fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
endtask
// ----
// Tests
// ----
initial begin
    logic [31:0] w;
    logic [1:0] k;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    for (int r = 0; r < 2; r++) begin
        for (int i = 0; i < 10; i++) begin
            w = 32'hC0DE0000 | 32'(i);
            apb(r == 0, 16'h8000 + 16'((i % 5) * 256 + (i / 5) * 252), w);
            if (r == 1) check(q, w);
        end
        // Refused writes land between the passes to expose aliasing.
        if (r == 0) foreach (bad[j]) begin
            apb(1'h1, bad[j], 32'hFFFFFFFF);
            check(32'(e), 32'h1);
            apb(1'h0, bad[j], 32'h0);
            check(q, 32'h0);
        end
    end
    lookup_bundle <= 6'h5;
    // Every plane of bundle 5 is written before its fields are used.
    apb(1'h1, 16'h8214, 32'h0);
    apb(1'h1, 16'h8314, 32'h00030000);
    apb(1'h1, 16'h8414, 32'h0);
    for (int i = 0; i < 4; i++) begin
        k = i[1:0];
        w = {10'h2F8 + 10'(i), k, k[0], k[1], k, 7'h55 ^ 7'(i),
            5'h1F - 5'(i), k[1], k, k[0]};
        apb(1'h1, 16'h8114, w);
        apb(1'h1, 16'h8014, ~w);
        repeat (2) @(posedge mclk);
        check(fields >> 16, w >> 16);
        check(fields & 16'hFFFF, w & 16'hFFFF);
        check(32'(aal1_selected), 32'(i == 1));
        check(rx_bundle_id, ~w);
    end
    give_verdict();
end
endmodule
`default_nettype wire
